/* dv/position_pwm_output_tb_top.sv */
`default_nettype none

module position_pwm_output_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] pos = 16'h0000;
    logic dir = 1'b0;
    logic err = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wd = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic clr = 1'b0;
    logic [15:0] rdata;
    logic [15:0] cpos;
    logic rvalid;
    logic rext;
    logic pwm;
    logic [16:0] hc;
    logic [16:0] per;
    int errors = 0;
    int checks = 0;

    initial
    begin
        forever #50 clk = ~clk;
    end

    position_pwm_output position_pwm_output_i (.clk(clk), .arst_n(arst_n),
        .linearized_position(pos), .magnet_direction_flag(dir),
        .error_flag(err), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .conditioned_position(cpos), .range_extension_enable(rext),
        .pwm_out(pwm));
    ppo_duty_meter ppo_duty_meter_i (.clk(clk), .pwm_out(pwm), .clr(clr),
        .high_cnt(hc), .period_len(per));

    task close_out;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out

    task chk(input string n, input logic [16:0] e, input logic [16:0] s);
        checks++;
        if (s !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt

    task wreg(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wreg

    task rreg(input logic [15:0] a, input logic [15:0] e);
        int i;
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        i = 0;
        while (rvalid !== 1'b1 && i < 3)
        begin
            @(negedge clk);
            i++;
        end
        if (i == 3)
        begin
            errors++;
            close_out();
        end
        chk("read data", {1'b0, e}, {1'b0, rdata});
    endtask : rreg

    // One period settles the latched duty, the next is counted
    task meas(input int p, input logic [16:0] e);
        wt(p);
        @(negedge clk);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        wt(p);
        chk("high time", e, hc);
    endtask : meas

    task regs_case;
        rreg(16'h000B, 16'h0000);
        rreg(16'h000D, 16'h0000);
        wreg(16'h000D, 16'hA5F0);
        rreg(16'h000D, 16'hA5F0);
        wreg(16'h0005, 16'hFFFF);
        rreg(16'h0005, 16'h0000);
        rreg(16'h000D, 16'hA5F0);
    endtask : regs_case

    task coord_case;
        dir = 1'b1;
        pos = 16'h1234;
        wreg(16'h000B, 16'h0C00);
        wt(2);
        chk("negated", 17'h0EDCC, {1'b0, cpos});
        chk("range ext", 17'h00001, {16'h0000, rext});
        pos = 16'h8000;
        wt(2);
        chk("saturated", 17'h07FFF, {1'b0, cpos});
        dir = 1'b0;
        wt(2);
        chk("flag clear", 17'h08000, {1'b0, cpos});
        dir = 1'b1;
        wreg(16'h000B, 16'h0000);
        wt(2);
        chk("select off", 17'h08000, {1'b0, cpos});
        chk("range ext", 17'h00000, {16'h0000, rext});
        dir = 1'b0;
    endtask : coord_case

    task scale_case;
        pos = 16'h0000;
        for (int p = 7; p >= 3; p--)
        begin
            wreg(16'h000D, {13'h1F81, p[2:0]});
            meas(1 << (16 - p), 17'h07FFF >> p);
            chk("period", 17'h00001 << (16 - p), per);
        end
    endtask : scale_case

    task duty_case;
        logic [15:0] pv[4] = '{16'h7FFF, 16'h0000, 16'h8000, 16'hC000};
        logic [16:0] ev[4] = '{17'h00000, 17'h000FF, 17'h00200, 17'h0017F};
        // The slow period from the last scale step must run out first
        wreg(16'h000D, 16'hFC0F);
        wt(8192);
        for (int i = 0; i < 4; i++)
        begin
            pos = pv[i];
            meas(512, ev[i]);
        end
    endtask : duty_case

    task clamp_case;
        wreg(16'h000D, 16'h03FF);
        pos = 16'h7FFF;
        meas(512, 17'h00100);
        pos = 16'h8000;
        meas(512, 17'h00100);
        wreg(16'h000D, 16'hBD0F);
        meas(512, 17'h001C0);
        pos = 16'h7FFF;
        meas(512, 17'h00040);
        pos = 16'h0000;
        meas(512, 17'h000FF);
    endtask : clamp_case

    task fault_case;
        wreg(16'h000D, 16'hFC0F);
        pos = 16'h8000;
        err = 1'b1;
        meas(512, 17'h00000);
        err = 1'b0;
        meas(512, 17'h00200);
        wreg(16'h000D, 16'hFC07);
        meas(512, 17'h00000);
    endtask : fault_case

    // Slow codes: enabling restarts the period, so only its first pulse
    // is timed; a full period would cost far too many cycles
    task code_case;
        pos = 16'h7FFF;
        for (int p = 0; p < 3; p++)
        begin
            wreg(16'h000D, {13'h1F00, p[2:0]});
            @(negedge clk);
            clr = 1'b1;
            @(negedge clk);
            clr = 1'b0;
            wreg(16'h000D, {13'h1F01, p[2:0]});
            wt(1024);
            chk("start pulse", 17'h00200 >> p, hc);
        end
    endtask : code_case

    initial
    begin
        wt(6);
        arst_n = 1'b1;
        regs_case();
        coord_case();
        scale_case();
        duty_case();
        clamp_case();
        fault_case();
        code_case();
        close_out();
    end
endmodule : position_pwm_output_tb_top

bind position_pwm_output ppo_checker ppo_checker_i (.clk, .arst_n,
    .linearized_position, .magnet_direction_flag, .error_flag, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .conditioned_position, .range_extension_enable, .pwm_out);

`default_nettype wire

/* dv/ppo_checker_properties.sv */
`default_nettype none

module ppo_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [15:0] linearized_position,
    input wire logic magnet_direction_flag,
    input wire logic error_flag,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [15:0] conditioned_position,
    input wire logic range_extension_enable,
    input wire logic pwm_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    rd_answer_a:
    assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    rd_cause_a:
    assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read valid without read");
    rd_unmapped_a:
    assert property (reg_rd && reg_addr != 16'h000B && reg_addr != 16'h000D
        |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    rdata_hold_a:
    assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved without read");
    error_zero_a:
    assert property (error_flag |=> !pwm_out)
        else $error("output high during error");
    disable_zero_a:
    assert property (reg_wr && reg_addr == 16'h000D && !reg_wdata[3]
        |-> ##3 !pwm_out)
        else $error("output high while disabled");
    range_ext_a:
    assert property (reg_wr && reg_addr == 16'h000B
        |-> ##2 range_extension_enable == $past(reg_wdata[11], 2))
        else $error("range extension bit not followed");
    sign_pass_a:
    assert property (!$past(magnet_direction_flag)
        |-> conditioned_position == $past(linearized_position))
        else $error("position changed without direction flag");
endmodule : ppo_checker

`default_nettype wire

/* dv/ppo_duty_meter.sv */
`default_nettype none

// Far-end controller: counts high samples since clr, and rise spacing
module ppo_duty_meter (
    input wire logic clk,
    input wire logic pwm_out,
    input wire logic clr,
    output logic [16:0] high_cnt,
    output logic [16:0] period_len
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev = 1'b0;
    logic [16:0] run_len = 17'h00000;

    always @(posedge clk)
    begin
        high_cnt <= clr ? 17'h00000 : high_cnt + {16'h0000, pwm_out};
        if (pwm_out && !prev)
        begin
            period_len <= run_len;
            run_len <= 17'h00001;
        end
        else
        begin
            run_len <= run_len + 17'h00001;
        end
        prev <= pwm_out;
    end
endmodule : ppo_duty_meter

`default_nettype wire

/* hw/position_pwm_output.sv */
`include "ppo_consts.svh"

`default_nettype none

module position_pwm_output (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [15:0] linearized_position,
    input wire logic magnet_direction_flag,
    input wire logic error_flag,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    output logic [15:0] conditioned_position,
    output logic range_extension_enable,
    output logic pwm_out
);

    // Register file
    logic [15:0] seq_ctrl_q;
    logic [15:0] seq_ctrl_d;
    logic [15:0] pulse_set_q;
    logic [15:0] pulse_set_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    always_comb
    begin
        seq_ctrl_d = seq_ctrl_q;
        pulse_set_d = pulse_set_q;
        rdata_d = rdata_q;
        rvalid_d = reg_rd;
        if (reg_wr)
        begin
            if (reg_addr == `PPO_ADDR_SEQ_CTRL)
            begin
                seq_ctrl_d = reg_wdata;
            end
            else if (reg_addr == `PPO_ADDR_PULSE_SET)
            begin
                pulse_set_d = reg_wdata;
            end
        end
        if (reg_rd)
        begin
            if (reg_addr == `PPO_ADDR_SEQ_CTRL)
            begin
                rdata_d = seq_ctrl_q;
            end
            else if (reg_addr == `PPO_ADDR_PULSE_SET)
            begin
                rdata_d = pulse_set_q;
            end
            else
            begin
                rdata_d = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            seq_ctrl_q <= `PPO_SEQ_CTRL_RST;
            pulse_set_q <= `PPO_PULSE_SET_RST;
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end
        else
        begin
            seq_ctrl_q <= seq_ctrl_d;
            pulse_set_q <= pulse_set_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    logic coord_sel;
    logic out_enable;
    ppo_pkg::ppo_bound_t lower_field;
    ppo_pkg::ppo_bound_t upper_field;
    ppo_pkg::ppo_prescale_t prescale_field;

    assign coord_sel = seq_ctrl_q[`PPO_COORD_SEL_BIT];
    assign out_enable = pulse_set_q[`PPO_EN_BIT];
    assign lower_field = pulse_set_q[`PPO_LB_MSB:`PPO_LB_LSB];
    assign upper_field = pulse_set_q[`PPO_UB_MSB:`PPO_UB_LSB];
    assign prescale_field = pulse_set_q[`PPO_PS_MSB:`PPO_PS_LSB];

    // Position conditioning
    logic [15:0] pos_adj;
    logic [15:0] pos_q;
    logic ext_q;

    always_comb
    begin
        pos_adj = linearized_position;
        if (coord_sel && magnet_direction_flag)
        begin
            // Negating the most negative code would wrap, so saturate it
            if (linearized_position == `PPO_POS_MIN)
            begin
                pos_adj = `PPO_POS_MAX;
            end
            else
            begin
                pos_adj = 16'h0000 - linearized_position;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pos_q <= 16'h0000;
            ext_q <= 1'b0;
        end
        else
        begin
            pos_q <= pos_adj;
            ext_q <= seq_ctrl_q[`PPO_RANGE_EXT_BIT];
        end
    end

    // Duty computation from the live prescale; latched at period start
    ppo_pkg::ppo_count_t min_off;
    ppo_pkg::ppo_count_t max_off;
    ppo_pkg::ppo_bound_t lower_inv;

    assign lower_inv = ~lower_field;

    ppo_bound_scale u_lower (
        .field(lower_inv),
        .prescale(prescale_field),
        .scaled(min_off)
    );

    ppo_bound_scale u_upper (
        .field(upper_field),
        .prescale(prescale_field),
        .scaled(max_off)
    );

    logic [15:0] duty_raw;
    logic [15:0] duty_shift;
    logic [15:0] res_mask;
    ppo_pkg::ppo_count_t high_raw;
    ppo_pkg::ppo_count_t period_new;
    ppo_pkg::ppo_count_t high_min;
    ppo_pkg::ppo_count_t high_max;
    ppo_pkg::ppo_count_t high_new;

    always_comb
    begin
        // Offset binary, inverted: 32767 -> 0, 0 -> half, -32768 -> full
        duty_raw = pos_q ^ `PPO_DUTY_FLIP;
        duty_shift = duty_raw >> prescale_field;
        res_mask = `PPO_FULL_MASK >> prescale_field;
        period_new = `PPO_FULL_PERIOD >> prescale_field;
        // Top code stretched to a full period so 100% is reachable
        high_raw = {1'b0, duty_shift} + {16'h0000, duty_shift == res_mask};
        high_min = min_off;
        high_max = period_new - max_off;
        high_new = high_raw;
        if (high_raw < high_min)
        begin
            high_new = high_min;
        end
        else if (high_raw > high_max)
        begin
            high_new = high_max;
        end
        if (error_flag)
        begin
            high_new = 17'h00000;
        end
    end

    // Pulse generator
    ppo_pkg::ppo_state_t state_q;
    ppo_pkg::ppo_state_t state_d;
    ppo_pkg::ppo_count_t cnt_q;
    ppo_pkg::ppo_count_t cnt_d;
    ppo_pkg::ppo_count_t high_q;
    ppo_pkg::ppo_count_t high_d;
    ppo_pkg::ppo_count_t period_q;
    ppo_pkg::ppo_count_t period_d;
    logic pwm_q;
    logic pwm_d;
    logic step;

    ppo_step_divider #(
        .CYC(`PPO_STEP_CYC)
    ) u_step (
        .clk(clk),
        .arst_n(arst_n),
        .run(out_enable),
        .tick(step)
    );

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        high_d = high_q;
        period_d = period_q;
        pwm_d = 1'b0;
        case (state_q)
            ppo_pkg::PPO_IDLE:
            begin
                cnt_d = 17'h00000;
                if (out_enable)
                begin
                    state_d = ppo_pkg::PPO_RUN;
                    high_d = high_new;
                    period_d = period_new;
                end
            end
            ppo_pkg::PPO_RUN:
            begin
                if (!out_enable)
                begin
                    state_d = ppo_pkg::PPO_IDLE;
                    cnt_d = 17'h00000;
                end
                else
                begin
                    pwm_d = cnt_q < high_q;
                    if (step)
                    begin
                        // New values only at a period edge, no runt pulses
                        if (cnt_q >= period_q - 17'h00001)
                        begin
                            cnt_d = 17'h00000;
                            high_d = high_new;
                            period_d = period_new;
                        end
                        else
                        begin
                            cnt_d = cnt_q + 17'h00001;
                        end
                    end
                end
            end
            default:
            begin
                state_d = ppo_pkg::PPO_IDLE;
            end
        endcase
        // An error takes effect at once, not at the next period
        if (error_flag)
        begin
            pwm_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= ppo_pkg::PPO_IDLE;
            cnt_q <= 17'h00000;
            high_q <= 17'h00000;
            period_q <= `PPO_FULL_PERIOD;
            pwm_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            high_q <= high_d;
            period_q <= period_d;
            pwm_q <= pwm_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign conditioned_position = pos_q;
    assign range_extension_enable = ext_q;
    assign pwm_out = pwm_q;

endmodule : position_pwm_output

`default_nettype wire

/* hw/ppo_bound_scale.sv */
`include "ppo_consts.svh"

`default_nettype none

// Maps a 6-bit field 0..63 onto 0..64 and scales it to a count of
// 64ths of half a period at the selected resolution.
module ppo_bound_scale (
    input wire ppo_pkg::ppo_bound_t field,
    input wire ppo_pkg::ppo_prescale_t prescale,
    output ppo_pkg::ppo_count_t scaled
);

    logic [6:0] stretched;
    logic [3:0] shift;

    // 63 lands exactly on 64 so the end codes reach 0% and 50% exactly
    assign stretched = {1'b0, field} + {6'h00, field[5]};
    assign shift = `PPO_SCALE_TOP - {1'b0, prescale};
    assign scaled = {10'h000, stretched} << shift;

endmodule : ppo_bound_scale

`default_nettype wire

/* hw/ppo_consts.svh */
`ifndef PPO_CONSTS_SVH
`define PPO_CONSTS_SVH

// Register word addresses
`define PPO_ADDR_SEQ_CTRL 16'h000B
`define PPO_ADDR_PULSE_SET 16'h000D

// Reset values
`define PPO_SEQ_CTRL_RST 16'h0000
`define PPO_PULSE_SET_RST 16'h0000

// Sequencer control fields
`define PPO_RANGE_EXT_BIT 11
`define PPO_COORD_SEL_BIT 10

// Pulse output settings fields
`define PPO_LB_MSB 15
`define PPO_LB_LSB 10
`define PPO_UB_MSB 9
`define PPO_UB_LSB 4
`define PPO_EN_BIT 3
`define PPO_PS_MSB 2
`define PPO_PS_LSB 0

// Position coding
`define PPO_POS_MAX 16'h7FFF
`define PPO_POS_MIN 16'h8000
`define PPO_DUTY_FLIP 16'h7FFF
`define PPO_FULL_MASK 16'hFFFF
`define PPO_FULL_PERIOD 17'h10000
`define PPO_SCALE_TOP 4'h9

// Timing
`define PPO_CLK_NS 100
`define PPO_STEP_NS 125
`define PPO_STEP_CYC \
    (((`PPO_STEP_NS / `PPO_CLK_NS) < 1) ? 1 : (`PPO_STEP_NS / `PPO_CLK_NS))

`endif

/* hw/ppo_pkg.sv */
`default_nettype none

package ppo_pkg;

    typedef logic [2:0] ppo_prescale_t;
    typedef logic [5:0] ppo_bound_t;
    typedef logic [16:0] ppo_count_t;

    typedef enum logic [0:0] {
        PPO_IDLE,
        PPO_RUN
    } ppo_state_t;

endpackage : ppo_pkg

`default_nettype wire

/* hw/ppo_step_divider.sv */
`default_nettype none

module ppo_step_divider #(
    parameter int unsigned CYC = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic run,
    output logic tick
);

    localparam logic [7:0] LAST = 8'(CYC - 1);

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic tick_q;
    logic tick_d;

    always_comb
    begin
        cnt_d = 8'h00;
        tick_d = 1'b0;
        if (run)
        begin
            if (cnt_q >= LAST)
            begin
                cnt_d = 8'h00;
                tick_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule : ppo_step_divider

`default_nettype wire
